// file: logic/baud_detect.sv
// Purpose: Detects the bus bit rate from the shortest low pulse on the receive line.
// Assumes: rxd_i is already synchronised to clk_i.
// Notes:   A fresh estimate is published after every window of low pulses.
`default_nettype none

module baud_detect (
	input  wire logic                            clk_i,   // System clock
	input  wire logic                            nrst_i,  // Asynchronous reset, active low
	input  wire logic                            rxd_i,   // Synchronised receive line
	output var  fieldbus_addr_pkg::baud_rate_e   rate_o,  // Detected rate
	output logic                                 lock_o   // Rate is valid
);

	logic [12:0] run_q;
	logic [12:0] min_q;
	logic [4:0]  edges_q;
	logic        rxd_q;
	fieldbus_addr_pkg::baud_rate_e rate_q;
	fieldbus_addr_pkg::baud_rate_e class_d;
	logic        lock_q;
	logic        pulse_end;

	assign pulse_end = rxd_i && !rxd_q;

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rxd_q <= 1'b1;
		else
			rxd_q <= rxd_i;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			run_q <= 13'h0000;
		else if (rxd_i)
			run_q <= 13'h0000;
		else if (run_q != fieldbus_addr_pkg::PULSE_SAT)
			run_q <= run_q + 13'h0001;
	end

	// The shortest low pulse is one bit; longer ones are runs of zero bits.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			min_q   <= fieldbus_addr_pkg::PULSE_SAT;
			edges_q <= 5'h00;
		end
		else if (pulse_end && edges_q == fieldbus_addr_pkg::BAUD_EDGES - 5'h01)
		begin
			min_q   <= fieldbus_addr_pkg::PULSE_SAT;
			edges_q <= 5'h00;
		end
		else if (pulse_end)
		begin
			if (run_q < min_q)
				min_q <= run_q;
			edges_q <= edges_q + 5'h01;
		end
	end

	always_comb
	begin
		if (min_q <= fieldbus_addr_pkg::THR_12M)
			class_d = fieldbus_addr_pkg::BAUD_12M;
		else if (min_q <= fieldbus_addr_pkg::THR_6M)
			class_d = fieldbus_addr_pkg::BAUD_6M;
		else if (min_q <= fieldbus_addr_pkg::THR_3M)
			class_d = fieldbus_addr_pkg::BAUD_3M;
		else if (min_q <= fieldbus_addr_pkg::THR_1M5)
			class_d = fieldbus_addr_pkg::BAUD_1M5;
		else if (min_q <= fieldbus_addr_pkg::THR_500K)
			class_d = fieldbus_addr_pkg::BAUD_500K;
		else if (min_q <= fieldbus_addr_pkg::THR_187K5)
			class_d = fieldbus_addr_pkg::BAUD_187K5;
		else if (min_q <= fieldbus_addr_pkg::THR_93K75)
			class_d = fieldbus_addr_pkg::BAUD_93K75;
		else if (min_q <= fieldbus_addr_pkg::THR_19K2)
			class_d = fieldbus_addr_pkg::BAUD_19K2;
		else if (min_q <= fieldbus_addr_pkg::THR_9K6)
			class_d = fieldbus_addr_pkg::BAUD_9K6;
		else
			class_d = fieldbus_addr_pkg::BAUD_NONE;
	end

	// R7: automatic rate choice
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rate_q <= fieldbus_addr_pkg::BAUD_NONE;
			lock_q <= 1'b0;
		end
		else if (pulse_end && edges_q == fieldbus_addr_pkg::BAUD_EDGES - 5'h01)
		begin
			rate_q <= class_d;
			lock_q <= (class_d != fieldbus_addr_pkg::BAUD_NONE);
		end
	end

	assign rate_o = rate_q;
	assign lock_o = lock_q;

	a_baud_lock_rate: assert property (@(posedge clk_i) disable iff (!nrst_i) // R7
		lock_o |-> rate_o != fieldbus_addr_pkg::BAUD_NONE)
		else $error("Baud lock without a rate");

endmodule // baud_detect

`default_nettype wire

// file: logic/fieldbus_addr_pkg.sv
// Purpose: Shared constants for the fieldbus slave address, baud and status logic.
// Assumes: A 40 MHz system clock.
// Notes:   Cycle counts are derived from the printed times and the clock rate.
`default_nettype none

package fieldbus_addr_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned LED_HALF_MS    = 1000;
	localparam int unsigned LED_HALF_CYC   = CLK_HZ / 1000 * LED_HALF_MS;
	localparam int unsigned FLASH_HOLD_MS  = 50;
	localparam int unsigned FLASH_HOLD_CYC = CLK_HZ / 1000 * FLASH_HOLD_MS;

	// ****************************************************************
	// Station address
	// ****************************************************************
	localparam logic [6:0] ADDR_MIN      = 7'h01;
	localparam logic [6:0] ADDR_MAX      = 7'h7D;
	localparam logic [6:0] ADDR_DEFAULT  = 7'h7E;
	localparam logic [6:0] ADDR_RESET    = 7'h00;
	localparam logic [3:0] SW_DEFAULT    = 4'hD;
	localparam logic [1:0] CAPTURE_DELAY = 2'h3;

	// ****************************************************************
	// Cyclic data image limits
	// ****************************************************************
	localparam logic [7:0] IN_LEN_MAX    = 8'h90;
	localparam logic [7:0] OUT_LEN_MAX   = 8'h12;
	localparam logic [8:0] TOTAL_LEN_MAX = 9'h0A2;

	// ****************************************************************
	// Baud detection
	// ****************************************************************
	typedef enum logic [3:0] {
		BAUD_NONE, BAUD_9K6, BAUD_19K2, BAUD_93K75, BAUD_187K5,
		BAUD_500K, BAUD_1M5, BAUD_3M, BAUD_6M, BAUD_12M
	} baud_rate_e;
	// Upper bounds of the shortest low pulse, in clock cycles, for each rate.
	localparam logic [12:0] THR_12M   = 13'h0004;
	localparam logic [12:0] THR_6M    = 13'h0009;
	localparam logic [12:0] THR_3M    = 13'h0013;
	localparam logic [12:0] THR_1M5   = 13'h0035;
	localparam logic [12:0] THR_500K  = 13'h0092;
	localparam logic [12:0] THR_187K5 = 13'h013F;
	localparam logic [12:0] THR_93K75 = 13'h04E6;
	localparam logic [12:0] THR_19K2  = 13'h0C34;
	localparam logic [12:0] THR_9K6   = 13'h1FFE;
	localparam logic [12:0] PULSE_SAT = 13'h1FFF;
	localparam logic [4:0]  BAUD_EDGES = 5'h10;

endpackage

`default_nettype wire

// file: logic/fieldbus_slave_address_status.sv
// Purpose: Station address capture, baud detection, status indicator and data image checks of a fieldbus slave.
// Assumes: Switch and receive pins are asynchronous; protocol engine signals share CLK_I.
// Notes:   The address is frozen after reset until the next reset.
// Notes on behaviour
// R1: The station address is read from the two rotary switches after reset and then enables bus operation.
// R2: Addresses 1 to 125 are used as set; a larger decoded value becomes 126.
// R3: The left switch is the tens digit and the right switch the units digit.
// R4: Either switch on position D forces address 126.
// R5: Switch movement while running leaves the active address unchanged until the next reset.
// R6: The indicator is steady for good cyclic exchange, flashes on acyclic traffic, and blinks 1 s on 1 s off otherwise.
// R7: The bit rate is detected automatically from the nine supported rates.
// R8: Configurations above 144 input, 18 output or 162 total bytes are refused.
// R9: Cyclic exchange goes with the class 1 master and acyclic exchange with the class 2 master.
// R10: Parameters come from non-volatile storage, so the slave is operational without bus parameterization.
// R11: Parameterization by the class 1 master is accepted only for the default configuration.
// R12: The sampled address is registered once after reset release and held until the next reset.
`default_nettype none

module fieldbus_slave_address_status #(
	parameter int unsigned LED_HALF_CYCLES = fieldbus_addr_pkg::LED_HALF_CYC,   // Blink half period
	parameter int unsigned FLASH_CYCLES    = fieldbus_addr_pkg::FLASH_HOLD_CYC  // Flash mode hold time
) (
	input  wire logic       CLK_I,           // System clock, 40 MHz
	input  wire logic       NRST_I,          // Asynchronous reset, active low
	input  wire logic [3:0] SW_TENS_I,       // Left rotary switch
	input  wire logic [3:0] SW_UNITS_I,      // Right rotary switch
	input  wire logic       RXD_I,           // Bus receive line
	input  wire logic       PARAM_LOADED_I,  // Stored parameters are loaded
	input  wire logic       CYC_OK_I,        // Cyclic exchange running
	input  wire logic       COMM_ERR_I,      // Communication error
	input  wire logic       ACYC_EV_I,       // Acyclic or other protocol frame seen
	input  wire logic       FRAME_I,         // Frame request strobe
	input  wire logic       FRAME_ACYC_I,    // Frame is acyclic
	input  wire logic       FRAME_CLASS2_I,  // Frame is from a class 2 master
	input  wire logic       CFG_REQ_I,       // Parameterization request strobe
	input  wire logic       CFG_DEFAULT_I,   // Requested configuration is the default
	input  wire logic [7:0] IN_LEN_I,        // Requested input bytes
	input  wire logic [7:0] OUT_LEN_I,       // Requested output bytes
	output logic      [6:0] STATION_ADDR_O,  // Active station address
	output logic            ADDR_VALID_O,    // Address captured
	output logic            OPERATIONAL_O,   // Slave ready for bus
	output logic      [3:0] BAUD_RATE_O,     // Detected rate code
	output logic            BAUD_LOCK_O,     // Rate detected
	output logic            LED_O,           // Communication indicator, high lit
	output logic            FRAME_OK_O,      // Frame accepted pulse
	output logic            FRAME_BAD_O,     // Frame refused pulse
	output logic            CFG_ACK_O,       // Parameterization accepted pulse
	output logic            CFG_NAK_O        // Parameterization refused pulse
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [3:0] tens_meta_q;
	logic [3:0] tens_sync_q;
	logic [3:0] units_meta_q;
	logic [3:0] units_sync_q;
	logic       rxd_meta_q;
	logic       rxd_sync_q;

	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			tens_meta_q  <= 4'h0;
			tens_sync_q  <= 4'h0;
			units_meta_q <= 4'h0;
			units_sync_q <= 4'h0;
			rxd_meta_q   <= 1'b1;
			rxd_sync_q   <= 1'b1;
		end
		else
		begin
			tens_meta_q  <= SW_TENS_I;
			tens_sync_q  <= tens_meta_q;
			units_meta_q <= SW_UNITS_I;
			units_sync_q <= units_meta_q;
			rxd_meta_q   <= RXD_I;
			rxd_sync_q   <= rxd_meta_q;
		end
	end

	// ****************************************************************
	// Station address
	// ****************************************************************
	logic [1:0] cap_cnt_q;
	logic [6:0] addr_q;
	logic [6:0] addr_d;
	logic       valid_q;

	function automatic logic [6:0] decode_addr(input logic [3:0] tens, input logic [3:0] units);
		logic [7:0] value;
		value = 8'(8'({4'h0, tens}) * 8'h0A) + 8'({4'h0, units});
		// R4: position D default
		if (tens == fieldbus_addr_pkg::SW_DEFAULT || units == fieldbus_addr_pkg::SW_DEFAULT)
			return fieldbus_addr_pkg::ADDR_DEFAULT;
		// R2: out of range default
		else if (value > 8'({1'b0, fieldbus_addr_pkg::ADDR_MAX}) || value == 8'h00)
			return fieldbus_addr_pkg::ADDR_DEFAULT;
		else
			return value[6:0];
	endfunction

	// R3: tens and units digits
	assign addr_d = decode_addr(tens_sync_q, units_sync_q);

	// The wait lets the synchronisers fill with the real switch level first.
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			cap_cnt_q <= 2'h0;
		else if (cap_cnt_q != fieldbus_addr_pkg::CAPTURE_DELAY)
			cap_cnt_q <= cap_cnt_q + 2'h1;
	end

	// R5: later moves ignored
	// R12: single capture after reset
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			addr_q  <= fieldbus_addr_pkg::ADDR_RESET;
			valid_q <= 1'b0;
		end
		else if (!valid_q && cap_cnt_q == fieldbus_addr_pkg::CAPTURE_DELAY)
		begin
			// R1: sample switches at start
			addr_q  <= addr_d;
			valid_q <= 1'b1;
		end
	end

	assign STATION_ADDR_O = addr_q;
	assign ADDR_VALID_O   = valid_q;

	// ****************************************************************
	// Operational state and baud rate
	// ****************************************************************
	logic oper_q;
	fieldbus_addr_pkg::baud_rate_e rate;

	// R10: no bus parameterization needed
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			oper_q <= 1'b0;
		else
			oper_q <= valid_q && PARAM_LOADED_I;
	end

	assign OPERATIONAL_O = oper_q;

	// R7: autobaud detector
	baud_detect u_baud (
		.clk_i  (CLK_I),
		.nrst_i (NRST_I),
		.rxd_i  (rxd_sync_q),
		.rate_o (rate),
		.lock_o (BAUD_LOCK_O)
	);

	assign BAUD_RATE_O = rate;

	// ****************************************************************
	// Communication indicator
	// ****************************************************************
	logic [25:0] blink_cnt_q;
	logic        blink_q;
	logic [21:0] flash_cnt_q;
	logic        flash_q;
	logic        led_q;

	// R6: one second blink timebase
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			blink_cnt_q <= 26'h0000000;
			blink_q     <= 1'b1;
		end
		else if (blink_cnt_q == 26'(LED_HALF_CYCLES - 1))
		begin
			blink_cnt_q <= 26'h0000000;
			blink_q     <= !blink_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 26'h0000001;
	end

	// Each acyclic frame toggles flash_q, which the lamp shows during the hold unless cyclic exchange is good or an error is present.
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			flash_cnt_q <= 22'h000000;
			flash_q     <= 1'b0;
		end
		else if (ACYC_EV_I)
		begin
			flash_cnt_q <= 22'(FLASH_CYCLES);
			flash_q     <= !flash_q;
		end
		else if (flash_cnt_q != 22'h000000)
			flash_cnt_q <= flash_cnt_q - 22'h000001;
	end

	// R6: indicator mode select
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			led_q <= 1'b0;
		else if (CYC_OK_I && !COMM_ERR_I)
			led_q <= 1'b1;
		else if (flash_cnt_q != 22'h000000 && !COMM_ERR_I)
			led_q <= flash_q;
		else
			led_q <= blink_q;
	end

	assign LED_O = led_q;

	// ****************************************************************
	// Frame class check and parameterization
	// ****************************************************************
	logic       frame_ok_q;
	logic       frame_bad_q;
	logic       cfg_ack_q;
	logic       cfg_nak_q;
	logic       len_ok;
	logic [8:0] total_len;

	// R9: class 1 cyclic, class 2 acyclic
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			frame_ok_q  <= 1'b0;
			frame_bad_q <= 1'b0;
		end
		else
		begin
			frame_ok_q  <= FRAME_I && oper_q && (FRAME_CLASS2_I == FRAME_ACYC_I);
			frame_bad_q <= FRAME_I && !(oper_q && (FRAME_CLASS2_I == FRAME_ACYC_I));
		end
	end

	assign total_len = {1'b0, IN_LEN_I} + {1'b0, OUT_LEN_I};

	// R8: data image limits
	assign len_ok = IN_LEN_I <= fieldbus_addr_pkg::IN_LEN_MAX && OUT_LEN_I <= fieldbus_addr_pkg::OUT_LEN_MAX
		&& total_len <= fieldbus_addr_pkg::TOTAL_LEN_MAX;

	// R11: default configuration only
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			cfg_ack_q <= 1'b0;
			cfg_nak_q <= 1'b0;
		end
		else
		begin
			cfg_ack_q <= CFG_REQ_I && CFG_DEFAULT_I && len_ok;
			cfg_nak_q <= CFG_REQ_I && !(CFG_DEFAULT_I && len_ok);
		end
	end

	assign FRAME_OK_O  = frame_ok_q;
	assign FRAME_BAD_O = frame_bad_q;
	assign CFG_ACK_O   = cfg_ack_q;
	assign CFG_NAK_O   = cfg_nak_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	sequence s_cfg_bad;
		CFG_REQ_I && !CFG_DEFAULT_I;
	endsequence

	sequence s_refused;
		CFG_NAK_O && !CFG_ACK_O;
	endsequence

	a_addr_capture: assert property (!ADDR_VALID_O ##1 !ADDR_VALID_O ##1 !ADDR_VALID_O |=> ##[0:1] ADDR_VALID_O) // R1
		else $error("Address not captured after reset");
	a_addr_range: assert property (ADDR_VALID_O |-> STATION_ADDR_O >= 7'h01 && STATION_ADDR_O <= 7'h7E) // R2
		else $error("Station address out of range");
	a_addr_decimal: assert property ($rose(ADDR_VALID_O) && $past(tens_sync_q) < 4'hA && $past(units_sync_q) < 4'hA // R3
		&& ($past(tens_sync_q) != 4'h0 || $past(units_sync_q) != 4'h0)
		|-> STATION_ADDR_O == 7'($past(tens_sync_q) * 7'h0A + $past(units_sync_q)))
		else $error("Digits not combined as tens and units");
	a_addr_dflt_d: assert property ($rose(ADDR_VALID_O) && ($past(tens_sync_q) == 4'hD || $past(units_sync_q) == 4'hD) // R4
		|-> STATION_ADDR_O == 7'h7E)
		else $error("Position D did not give the default address");
	a_addr_hold: assert property (ADDR_VALID_O |=> ADDR_VALID_O && $stable(STATION_ADDR_O)) // R5
		else $error("Active address changed while running");
	a_led_solid: assert property (CYC_OK_I && !COMM_ERR_I |=> LED_O) // R6
		else $error("Indicator not steady during cyclic exchange");
	a_led_blink_step: assert property (blink_cnt_q == 26'(LED_HALF_CYCLES - 1) |=> blink_q != $past(blink_q)) // R6
		else $error("Blink did not toggle at half period");
	a_led_err_blink: assert property (COMM_ERR_I |=> LED_O == $past(blink_q)) // R6
		else $error("Indicator not blinking on communication error");
	a_cfg_len_limit: assert property (CFG_REQ_I && (IN_LEN_I > 8'h90 || OUT_LEN_I > 8'h12) |=> s_refused) // R8
		else $error("Oversized data image accepted");
	a_frame_class: assert property (FRAME_I && FRAME_CLASS2_I != FRAME_ACYC_I |=> FRAME_BAD_O && !FRAME_OK_O) // R9
		else $error("Frame with wrong master class accepted");
	a_oper_needs: assert property (OPERATIONAL_O |-> $past(ADDR_VALID_O) && $past(PARAM_LOADED_I)) // R10
		else $error("Operational without address or parameters");
	a_cfg_default: assert property (s_cfg_bad |=> s_refused) // R11
		else $error("Non-default configuration accepted");
	a_addr_once: assert property ($rose(ADDR_VALID_O) |-> cap_cnt_q == 2'h3) // R12
		else $error("Address captured at the wrong time");

endmodule // fieldbus_slave_address_status

`default_nettype wire

// file: testbench/bus_master_model.sv
// Purpose: Stand-in for the bus master: drives the receive line and the protocol strobes.
// Assumes: Callers enter each task one nanosecond after a rising clock edge.
// Notes:   Qualifiers are inverted after release so a stale value never looks valid.
`default_nettype none

module bus_master_model (
	input  wire logic       clk_i,          // System clock
	output var  logic       rxd_o,          // Receive line, idles high
	output var  logic       frame_o,        // Frame strobe
	output var  logic       frame_acyc_o,   // Frame is acyclic
	output var  logic       frame_class2_o, // Frame from class 2 master
	output var  logic       cfg_req_o,      // Parameterization strobe
	output var  logic       cfg_default_o,  // Default configuration asked
	output var  logic [7:0] in_len_o,       // Requested input bytes
	output var  logic [7:0] out_len_o       // Requested output bytes
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		rxd_o = 1'h1;
		frame_o = 1'h0;
		frame_acyc_o = 1'h0;
		frame_class2_o = 1'h1;
		cfg_req_o = 1'h0;
		cfg_default_o = 1'h0;
		in_len_o = 8'hFF;
		out_len_o = 8'hFF;
	end

	task automatic send_pulses(input int width);
		for (int i = 0; i < 16; i++)
		begin
			rxd_o = 1'h0;
			repeat (width) @(posedge clk_i);
			#1 rxd_o = 1'h1;
			repeat (width) @(posedge clk_i);
			#1;
		end
	endtask

	task automatic send_frame(input logic acyc, input logic wrong_class);
		frame_o = 1'h1;
		frame_acyc_o = acyc;
		frame_class2_o = acyc ^ wrong_class;
		@(posedge clk_i);
		#1 frame_o = 1'h0;
		frame_acyc_o = ~frame_acyc_o;
		frame_class2_o = ~frame_class2_o;
	endtask

	task automatic send_cfg(input logic dflt, input logic [7:0] in_len, input logic [7:0] out_len);
		cfg_req_o = 1'h1;
		cfg_default_o = dflt;
		in_len_o = in_len;
		out_len_o = out_len;
		@(posedge clk_i);
		#1 cfg_req_o = 1'h0;
		cfg_default_o = ~cfg_default_o;
		in_len_o = ~in_len_o;
		out_len_o = ~out_len_o;
	endtask
endmodule // bus_master_model

`default_nettype wire

// file: testbench/fieldbus_slave_address_status_tb.sv
// Purpose: Self-checking bench for address capture, status indicator, frames, configuration and baud.
// Assumes: Short blink and flash counts are set at the instance.
// Notes:   Each scenario except the configuration one resets the block itself so it can run alone.
`default_nettype none

module fieldbus_slave_address_status_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// *****************************************
	// Stimulus tables: address (tens, units, address), configuration and baud cases
	// *****************************************
	localparam logic [15:0] ADDR_CASES [9] = '{16'h0707, 16'h8757, 16'hC57D, 16'hC67E, 16'h007E,
		16'hD37E, 16'h3D7E, 16'h0101, 16'hA064};
	localparam logic [19:0] CFG_CASES [6] = '{20'h39012, 20'h29100, 20'h20013, 20'h00101, 20'h30000, 20'h2FFFF};
	localparam logic [15:0] BAUD_CASES [4] = '{16'h9003, 16'h601B, 16'h5064, 16'h31AB};

	logic       clk, nrst, param_loaded, cyc_ok, comm_err, acyc_ev;
	logic [3:0] sw_tens, sw_units;
	logic       rxd, frame, frame_acyc, frame_class2, cfg_req, cfg_default;
	logic [7:0] in_len, out_len;
	logic [6:0] station_addr;
	logic [3:0] baud_rate;
	logic       addr_valid, operational, baud_lock, led, frame_ok, frame_bad, cfg_ack, cfg_nak;
	int         miscompares = 0;
	int         compares = 0;

	fieldbus_slave_address_status #(.LED_HALF_CYCLES(8), .FLASH_CYCLES(4)) u_dut (
		.CLK_I(clk), .NRST_I(nrst), .SW_TENS_I(sw_tens), .SW_UNITS_I(sw_units), .RXD_I(rxd),
		.PARAM_LOADED_I(param_loaded), .CYC_OK_I(cyc_ok), .COMM_ERR_I(comm_err), .ACYC_EV_I(acyc_ev),
		.FRAME_I(frame), .FRAME_ACYC_I(frame_acyc), .FRAME_CLASS2_I(frame_class2), .CFG_REQ_I(cfg_req),
		.CFG_DEFAULT_I(cfg_default), .IN_LEN_I(in_len), .OUT_LEN_I(out_len), .STATION_ADDR_O(station_addr),
		.ADDR_VALID_O(addr_valid), .OPERATIONAL_O(operational), .BAUD_RATE_O(baud_rate),
		.BAUD_LOCK_O(baud_lock), .LED_O(led), .FRAME_OK_O(frame_ok), .FRAME_BAD_O(frame_bad),
		.CFG_ACK_O(cfg_ack), .CFG_NAK_O(cfg_nak));

	bus_master_model u_master (
		.clk_i(clk), .rxd_o(rxd), .frame_o(frame), .frame_acyc_o(frame_acyc), .frame_class2_o(frame_class2),
		.cfg_req_o(cfg_req), .cfg_default_o(cfg_default), .in_len_o(in_len), .out_len_o(out_len));

	initial
	begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic do_reset(input logic [3:0] tens, input logic [3:0] units);
		nrst = 1'h0;
		sw_tens = tens;
		sw_units = units;
		tick(16);
		nrst = 1'h1;
		tick(6);
	endtask

	task automatic test_addr();
		for (int i = 0; i < 9; i++)
		begin
			do_reset(ADDR_CASES[i][15:12], ADDR_CASES[i][11:8]);
			check(8'(station_addr), ADDR_CASES[i][7:0], "address");
			check(8'(addr_valid), 8'h01, "address valid");
		end
		$display("test address decode done");
	endtask

	task automatic test_hold();
		do_reset(4'h4, 4'h2);
		sw_tens = 4'h9;
		sw_units = 4'h9;
		tick(10);
		check(8'(station_addr), 8'h2A, "address held");
		nrst = 1'h0;
		tick(1);
		check(8'(station_addr), 8'h00, "address in reset");
		do_reset(4'h9, 4'h9);
		check(8'(station_addr), 8'h63, "address after reset");
		$display("test address hold done");
	endtask

	task automatic test_frame();
		logic bad;
		param_loaded = 1'h0;
		do_reset(4'h1, 4'h0);
		check(8'(operational), 8'h00, "not operational");
		u_master.send_frame(1'h0, 1'h0);
		check(8'(frame_bad), 8'h01, "frame before ready");
		param_loaded = 1'h1;
		tick(2);
		check(8'(operational), 8'h01, "operational");
		for (int i = 0; i < 4; i++)
		begin
			bad = i[1];
			u_master.send_frame(i[0], bad);
			check(8'(frame_ok), 8'(!bad), "frame accepted");
			check(8'(frame_bad), 8'(bad), "frame refused");
			tick(1);
			check(8'(frame_ok | frame_bad), 8'h00, "frame pulse width");
		end
		$display("test frame done");
	endtask

	task automatic test_cfg();
		logic [19:0] c;
		for (int i = 0; i < 6; i++)
		begin
			c = CFG_CASES[i];
			u_master.send_cfg(c[17], c[15:8], c[7:0]);
			check(8'(cfg_ack), 8'(c[16]), "config ack");
			check(8'(cfg_nak), 8'(!c[16]), "config nak");
			tick(1);
			check(8'(cfg_ack | cfg_nak), 8'h00, "config pulse width");
		end
		$display("test config done");
	endtask

	task automatic test_led();
		logic lit;
		int   n;
		do_reset(4'h1, 4'h0);
		lit = led;
		n = 0;
		while (led === lit && n < 40)
		begin
			tick(1);
			n++;
		end
		lit = led;
		for (int i = 0; i < 8; i++)
		begin
			check(8'(led), 8'(lit), "blink phase");
			tick(1);
		end
		check(8'(led), 8'(!lit), "blink toggle");
		cyc_ok = 1'h1;
		tick(2);
		for (int i = 0; i < 12; i++)
		begin
			check(8'(led), 8'h01, "steady");
			tick(1);
		end
		cyc_ok = 1'h0;
		for (int i = 0; i < 2; i++)
		begin
			acyc_ev = 1'h1;
			tick(1);
			acyc_ev = 1'h0;
			tick(1);
			check(8'(led), 8'(i == 0), "flash");
		end
		// An error must win over good cyclic exchange: a full blink period is half lit.
		comm_err = 1'h1;
		cyc_ok = 1'h1;
		tick(2);
		n = 0;
		for (int i = 0; i < 16; i++)
		begin
			n += int'(led);
			tick(1);
		end
		check(8'(n), 8'h08, "blink on error");
		comm_err = 1'h0;
		cyc_ok = 1'h0;
		$display("test indicator done");
	endtask

	task automatic test_baud();
		do_reset(4'h1, 4'h0);
		check(8'(baud_lock), 8'h00, "no lock at start");
		for (int i = 0; i < 4; i++)
		begin
			u_master.send_pulses(int'(BAUD_CASES[i][11:0]));
			tick(6);
			check(8'(baud_rate), 8'(BAUD_CASES[i][15:12]), "baud rate");
			check(8'(baud_lock), 8'h01, "baud lock");
		end
		$display("test baud done");
	endtask

	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Runs well past the expected span so only a hang reaches it.
	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		test_done();
	end

	initial
	begin
		nrst = 1'h0;
		sw_tens = 4'h0;
		sw_units = 4'h0;
		param_loaded = 1'h1;
		cyc_ok = 1'h0;
		comm_err = 1'h0;
		acyc_ev = 1'h0;
		test_addr();
		test_hold();
		test_frame();
		test_cfg();
		test_led();
		test_baud();
		test_done();
	end
endmodule // fieldbus_slave_address_status_tb

`default_nettype wire
